/* design/srn_pkg.sv */
// Constants, register map and state layout of the serial receiver/transmitter.
// Assumes a single 20 MHz clock and a word-indexed Avalon-MM register port.
package srn_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [3:0] IDX_BDH  = 4'h0;
   localparam logic [3:0] IDX_BDL  = 4'h1;
   localparam logic [3:0] IDX_CR1  = 4'h2;
   localparam logic [3:0] IDX_ASR1 = 4'h0;
   localparam logic [3:0] IDX_ACR1 = 4'h1;
   localparam logic [3:0] IDX_ACR2 = 4'h2;
   localparam logic [3:0] IDX_CR2  = 4'h3;
   localparam logic [3:0] IDX_SR1  = 4'h4;
   localparam logic [3:0] IDX_SR2  = 4'h5;
   localparam logic [3:0] IDX_DATA = 4'h7;
   localparam logic [3:0] IDX_IST  = 4'h8;
   localparam logic [3:0] IDX_IMSK = 4'h9;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] BDH_RST  = 8'h00;
   localparam logic [7:0] BDL_RST  = 8'h04;
   localparam logic [7:0] CTL_RST  = 8'h00;
   localparam logic [2:0] SYNC_RST = 3'h7;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CR1_LOOPS = 7;
   localparam int CR1_PE    = 1;
   localparam int CR1_PT    = 0;
   localparam int CR2_TE    = 3;
   localparam int CR2_RE    = 2;
   localparam int SR2_AMAP  = 7;
   localparam int SR2_TXPOL = 4;
   localparam int SR2_RXPOL = 3;
   localparam logic [7:0] ACR1_MASK = 8'h83;

   // Interrupt status and mask layout.
   localparam int EV_RX    = 0;
   localparam int EV_TX    = 1;
   localparam int EV_NOISE = 2;
   localparam int EV_FRAME = 3;
   localparam int EV_OVER  = 4;
   localparam int EV_PAR   = 5;
   localparam int EV_EDGE  = 6;
   localparam int EV_W     = 7;

   // ----------------------------------------------------------------
   // Oversampling tick positions within one bit time, and bit numbers within a frame
   // ----------------------------------------------------------------
   localparam logic [3:0] TK_VER_A  = 4'h3;
   localparam logic [3:0] TK_VER_B  = 4'h5;
   localparam logic [3:0] TK_VER_C  = 4'h7;
   localparam logic [3:0] TK_DAT_A  = 4'h8;
   localparam logic [3:0] TK_DAT_B  = 4'h9;
   localparam logic [3:0] TK_DAT_C  = 4'ha;
   localparam logic [3:0] TK_LAST   = 4'hf;
   localparam logic [3:0] BIT_DATA  = 4'h8;
   localparam logic [3:0] BIT_STOP  = 4'h9;

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_BITS  = 2'b10
   } srn_rx_t;

   typedef enum logic [0:0] {
      TX_IDLE  = 1'b0,
      TX_SHIFT = 1'b1
   } srn_tx_t;

   typedef struct packed {
      logic [2:0]      sync;
      logic            rx_lvl;
      logic            rx_prev;
      logic            wait_q;
      logic            cap;
      logic            irq;
      logic            txd;
      logic [31:0]     rdata;
      logic [7:0]      bdh;
      logic [7:0]      bdl;
      logic [7:0]      cr1;
      logic [7:0]      cr2;
      logic [7:0]      sr2;
      logic [7:0]      acr1;
      logic [7:0]      acr2;
      logic [EV_W-1:0] ist;
      logic [EV_W-1:0] imsk;
      logic [15:0]     bcnt;
      srn_rx_t         rx_st;
      logic [3:0]      tk;
      logic [3:0]      bitn;
      logic [1:0]      smp;
      logic            rnf;
      logic            rpe;
      logic            rpar;
      logic [7:0]      rsh;
      logic [7:0]      rdat;
      logic            rdrf;
      logic            ovr;
      logic            noise;
      logic            fe;
      logic            pf;
      srn_tx_t         tx_st;
      logic [3:0]      tt;
      logic [3:0]      tbit;
      logic [10:0]     tsh;
      logic [7:0]      tbuf;
      logic            tdre;
      logic            tc;
   } srn_state_t;

endpackage : srn_pkg

/* design/srn_top.sv */
// Asynchronous serial port with register map, 16x oversampled receiver and
// transmitter, sticky interrupt status and one level interrupt.
// Assumes a word-indexed Avalon-MM master on the same clock and an
// asynchronous serial line on rxd.
//
// What this block does
// [R01] Reserved locations ignore writes and read back as zero.
// [R02] Each register answers at base plus its fixed offset, from zero.
// [R03] A high start verification sample at tick 3 sets noise, reception continues.
// [R04] A high start test sample at tick 5 sets noise, start still accepted.
// [R05] Each bit value is recovered from samples at ticks 8, 9 and 10.
// [R06] Sixteen ticks per bit from the baud divider; restart on start edge.
`timescale 1ns/1ps
module srn_top (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  byteenable,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic        rxd,
   output logic             txd,
   output logic             irq
);

   srn_pkg::srn_state_t s;
   srn_pkg::srn_state_t n;

   logic                    tick;
   logic                    rx_bit;
   logic                    fall;
   logic                    acc;
   logic                    alt;
   logic [3:0]              r;
   logic [3:0]              stop_bit;
   logic                    v;
   logic [15:0]             div;
   logic [31:0]             rv;
   logic [srn_pkg::EV_W-1:0] ev;

   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction : maj3

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n        = s;
      ev       = '0;
      rv       = '0;
      r        = 4'h0;
      v        = 1'b0;
      tick     = 1'b0;
      stop_bit = srn_pkg::BIT_STOP + {3'h0, s.cr1[srn_pkg::CR1_PE]};
      div      = {s.bdh, s.bdl};
      alt      = s.sr2[srn_pkg::SR2_AMAP];
      acc      = (read | write) & ~s.wait_q;

      // ----------------------------------------------------------------
      // Line input
      // ----------------------------------------------------------------
      // Three stages, a change is taken once the last two agree.
      // The extra level stage costs a clock of latency but keeps a
      // metastable first stage from ever reaching the edge detector.
      n.sync = {s.sync[1:0], rxd};
      if (s.sync[1] == s.sync[2]) begin
         n.rx_lvl = s.sync[2];
      end
      if (s.cr1[srn_pkg::CR1_LOOPS]) begin
         rx_bit = s.txd ^ s.sr2[srn_pkg::SR2_TXPOL];
      end else begin
         rx_bit = s.rx_lvl ^ s.sr2[srn_pkg::SR2_RXPOL];
      end
      fall      = s.rx_prev & ~rx_bit;
      n.rx_prev = rx_bit;
      if (fall) begin
         ev[srn_pkg::EV_EDGE] = 1'b1;
      end

      // ----------------------------------------------------------------
      // Baud divider
      // ----------------------------------------------------------------
      // The divider runs free, so the first tick after a start edge lands
      // up to one tick early; the start and data windows absorb that.
      // [R06] oversampling tick divider
      if (div == 16'h0000) begin
         n.bcnt = 16'h0000;
      end else if (s.bcnt >= 16'(div - 16'h0001)) begin
         n.bcnt = 16'h0000;
         tick   = 1'b1;
      end else begin
         n.bcnt = 16'(s.bcnt + 16'h0001);
      end

      // ----------------------------------------------------------------
      // Register bus
      // ----------------------------------------------------------------
      // Every access sees exactly one wait cycle, so software timing does
      // not depend on which register is addressed.
      // Read data is captured one cycle ahead of the answer edge.
      // [R02] register decode at base plus offset
      if (alt && address == srn_pkg::IDX_ASR1) begin
         rv[7] = s.ist[srn_pkg::EV_EDGE];
      end else if (alt && address == srn_pkg::IDX_ACR1) begin
         rv[7:0] = s.acr1;
      end else if (alt && address == srn_pkg::IDX_ACR2) begin
         rv[7:0] = s.acr2;
      end else if (address == srn_pkg::IDX_BDH) begin
         rv[7:0] = s.bdh;
      end else if (address == srn_pkg::IDX_BDL) begin
         rv[7:0] = s.bdl;
      end else if (address == srn_pkg::IDX_CR1) begin
         rv[7:0] = s.cr1;
      end else if (address == srn_pkg::IDX_CR2) begin
         rv[7:0] = s.cr2;
      end else if (address == srn_pkg::IDX_SR1) begin
         rv[7:0] = {s.tdre, s.tc, s.rdrf, (s.rx_st == srn_pkg::RX_IDLE) & rx_bit,
                    s.ovr, s.noise, s.fe, s.pf};
      end else if (address == srn_pkg::IDX_SR2) begin
         rv[7:0] = s.sr2;
      end else if (address == srn_pkg::IDX_DATA) begin
         rv[7:0] = s.rdat;
      end else if (address == srn_pkg::IDX_IST) begin
         rv[srn_pkg::EV_W-1:0] = s.ist;
      end else if (address == srn_pkg::IDX_IMSK) begin
         rv[srn_pkg::EV_W-1:0] = s.imsk;
      end else begin
         // [R01] reserved reads return zero
         rv = '0;
      end

      n.wait_q = 1'b1;
      if ((read | write) && s.wait_q) begin
         n.wait_q = 1'b0;
         n.rdata  = read ? rv : 32'h0000_0000;
         n.cap    = s.rdrf;
      end

      // Writes take effect at the answer edge; reserved locations fall through.
      // [R01] reserved writes have no effect
      if (acc && write && byteenable[0]) begin
         if (alt && address == srn_pkg::IDX_ASR1) begin
            n.ist[srn_pkg::EV_EDGE] = s.ist[srn_pkg::EV_EDGE] & ~writedata[7];
         end else if (alt && address == srn_pkg::IDX_ACR1) begin
            n.acr1 = writedata[7:0] & srn_pkg::ACR1_MASK;
         end else if (alt && address == srn_pkg::IDX_ACR2) begin
            n.acr2 = writedata[7:0];
         end else if (address == srn_pkg::IDX_BDH) begin
            n.bdh = writedata[7:0];
         end else if (address == srn_pkg::IDX_BDL) begin
            n.bdl = writedata[7:0];
         end else if (address == srn_pkg::IDX_CR1) begin
            n.cr1 = writedata[7:0];
         end else if (address == srn_pkg::IDX_CR2) begin
            n.cr2 = writedata[7:0];
         end else if (address == srn_pkg::IDX_SR2) begin
            n.sr2 = writedata[7:0];
         end else if (address == srn_pkg::IDX_DATA) begin
            // A write while the holding buffer is full is dropped.
            if (s.tdre) begin
               n.tbuf = writedata[7:0];
               n.tdre = 1'b0;
            end
         end else if (address == srn_pkg::IDX_IST) begin
            n.ist = s.ist & ~writedata[srn_pkg::EV_W-1:0];
         end else if (address == srn_pkg::IDX_IMSK) begin
            n.imsk = writedata[srn_pkg::EV_W-1:0];
         end
      end

      // Reading data retires the frame flags, but only if the capture saw
      // the frame; a frame landing between capture and answer survives.
      if (acc && read && address == srn_pkg::IDX_DATA && s.cap) begin
         n.rdrf = 1'b0;
         n.ovr  = 1'b0;
         n.noise = 1'b0;
         n.fe   = 1'b0;
         n.pf   = 1'b0;
      end

      // ----------------------------------------------------------------
      // Receiver
      // ----------------------------------------------------------------
      r = 4'(s.tk + 4'h1);
      case (s.rx_st)
         srn_pkg::RX_IDLE: begin
            if (s.cr2[srn_pkg::CR2_RE] && fall) begin
               // [R06] restart tick count at edge
               n.rx_st = srn_pkg::RX_START;
               n.tk    = 4'h0;
               n.smp   = 2'b00;
               n.rnf   = 1'b0;
               n.rpar  = 1'b0;
               n.rpe   = 1'b0;
            end
         end
         // A start bit must read low at ticks 3, 5 and 7 by majority.
         srn_pkg::RX_START: begin
            if (tick) begin
               n.tk = r;
               if (r == srn_pkg::TK_VER_A) begin
                  n.smp[0] = rx_bit;
               end else if (r == srn_pkg::TK_VER_B) begin
                  n.smp[1] = rx_bit;
               end else if (r == srn_pkg::TK_VER_C) begin
                  if (maj3(s.smp[0], s.smp[1], rx_bit)) begin
                     // Mostly high: a glitch, not a start bit.
                     n.rx_st = srn_pkg::RX_IDLE;
                  end else begin
                     // [R03] tick 3 high flags noise
                     // [R04] tick 5 high flags noise
                     n.rnf   = s.smp[0] | s.smp[1] | rx_bit;
                     n.rx_st = srn_pkg::RX_BITS;
                     n.bitn  = 4'h0;
                  end
               end
            end
         end
         srn_pkg::RX_BITS: begin
            if (tick) begin
               n.tk = r;
               if (r == 4'h0) begin
                  n.bitn = 4'(s.bitn + 4'h1);
               end
               // [R05] samples at ticks 8 9 10
               if (r == srn_pkg::TK_DAT_A) begin
                  n.smp[0] = rx_bit;
               end else if (r == srn_pkg::TK_DAT_B) begin
                  n.smp[1] = rx_bit;
               end else if (r == srn_pkg::TK_DAT_C && s.bitn != 4'h0) begin
                  v = maj3(s.smp[0], s.smp[1], rx_bit);
                  if (!(s.smp[0] == s.smp[1] && s.smp[1] == rx_bit)) begin
                     n.rnf = 1'b1;
                  end
                  if (s.bitn <= srn_pkg::BIT_DATA) begin
                     n.rsh  = {v, s.rsh[7:1]};
                     n.rpar = s.rpar ^ v;
                  end else if (s.bitn != stop_bit) begin
                     n.rpe = (s.rpar ^ v) != s.cr1[srn_pkg::CR1_PT];
                  end else begin
                     n.rx_st = srn_pkg::RX_IDLE;
                     ev[srn_pkg::EV_RX] = 1'b1;
                     if (s.rdrf && n.rdrf) begin
                        // Unread data is kept and the new frame is lost.
                        n.ovr = 1'b1;
                        ev[srn_pkg::EV_OVER] = 1'b1;
                     end else begin
                        n.rdat = s.rsh;
                        n.rdrf = 1'b1;
                        n.noise = n.rnf;
                        n.fe   = ~v;
                        n.pf   = s.rpe;
                        ev[srn_pkg::EV_NOISE] = n.rnf;
                        ev[srn_pkg::EV_FRAME] = ~v;
                        ev[srn_pkg::EV_PAR]   = s.rpe;
                     end
                  end
               end
            end
         end
         default: begin
            n.rx_st = srn_pkg::RX_IDLE;
         end
      endcase

      // ----------------------------------------------------------------
      // Transmitter
      // ----------------------------------------------------------------
      case (s.tx_st)
         srn_pkg::TX_IDLE: begin
            if (s.cr2[srn_pkg::CR2_TE] && !s.tdre && tick) begin
               n.tsh   = {1'b1,
                          s.cr1[srn_pkg::CR1_PE] ? (^s.tbuf) ^ s.cr1[srn_pkg::CR1_PT] : 1'b1,
                          s.tbuf, 1'b0};
               n.tt    = 4'h0;
               n.tbit  = 4'h0;
               n.tdre  = 1'b1;
               n.tc    = 1'b0;
               n.tx_st = srn_pkg::TX_SHIFT;
            end
         end
         srn_pkg::TX_SHIFT: begin
            if (tick) begin
               n.tt = 4'(s.tt + 4'h1);
               if (s.tt == srn_pkg::TK_LAST) begin
                  if (s.tbit == stop_bit) begin
                     n.tx_st = srn_pkg::TX_IDLE;
                     n.tc    = 1'b1;
                     ev[srn_pkg::EV_TX] = 1'b1;
                  end else begin
                     n.tsh  = {1'b1, s.tsh[10:1]};
                     n.tbit = 4'(s.tbit + 4'h1);
                  end
               end
            end
         end
         default: begin
            n.tx_st = srn_pkg::TX_IDLE;
         end
      endcase
      // The pin idles at the stop level so an enable never sends a false start.
      n.txd = ((n.tx_st == srn_pkg::TX_SHIFT) ? n.tsh[0] : 1'b1)
              ^ n.sr2[srn_pkg::SR2_TXPOL];

      // Events are merged last so a set always beats a clear in the same cycle.
      n.ist = n.ist | ev;
      n.irq = |(n.ist & n.imsk);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset puts the line stages at idle high so no false edge follows it.
   always_ff @(posedge clock) begin
      if (reset) begin
         s         <= '0;
         s.sync    <= srn_pkg::SYNC_RST;
         s.rx_lvl  <= 1'b1;
         s.rx_prev <= 1'b1;
         s.wait_q  <= 1'b1;
         s.txd     <= 1'b1;
         s.bdh     <= srn_pkg::BDH_RST;
         s.bdl     <= srn_pkg::BDL_RST;
         s.cr1     <= srn_pkg::CTL_RST;
         s.cr2     <= srn_pkg::CTL_RST;
         s.sr2     <= srn_pkg::CTL_RST;
         s.tdre    <= 1'b1;
         s.tc      <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign readdata    = s.rdata;
   assign waitrequest = s.wait_q;
   assign txd         = s.txd;
   assign irq         = s.irq;

endmodule : srn_top

/* tb/srn_far_tx.sv */
// Remote serial transmitter: idle-high line, 8 data bits LSB first, one stop.
// Assumes the receiver's bit time equals BIT_CLKS clocks of the bench clock.
`timescale 1ns/1ps
module srn_far_tx #(
   parameter int BIT_CLKS = 64
) (
   input  wire logic clock,
   output logic      rxd
);
   initial rxd = 1'b1;

   // Glitch 1 flips eight clocks of the start bit, which spans exactly one
   // of the start check samples whatever the tick phase; glitch 2 flips four
   // clocks at the middle of data bit 0, so one of its three samples is hit.
   task automatic send(input logic [7:0] data, input int glitch);
      logic [9:0] frame;
      logic       flip;
      int         b;
      int         c;
      frame = {1'b1, data, 1'b0};
      for (b = 0; b < 10; b++) begin
         for (c = 0; c < BIT_CLKS; c++) begin
            flip = (glitch == 1 && b == 0 && c >= 12 && c < 20) ||
                   (glitch == 2 && b == 1 && c >= 32 && c < 36);
            @(posedge clock);
            rxd <= frame[b] ^ flip;
         end
      end
   endtask : send
endmodule : srn_far_tx

/* tb/srn_sva.sv */
// Checker for the serial port's register bus, reset state and interrupt line.
// Assumes the port names of srn_top and one clock domain.
`timescale 1ns/1ps
module srn_sva (
   input wire logic        clock,
   input wire logic        reset,
   input wire logic [3:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        rxd,
   input wire logic        txd,
   input wire logic        irq
);
   logic [6:0] mask_q;
   logic [6:0] mask_d;

   // A shadow of the mask lets a zero mask be tied to a quiet interrupt.
   always_comb begin
      mask_d = mask_q;
      if (write && !waitrequest && byteenable[0] && address == 4'h9) begin
         mask_d = writedata[6:0];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         mask_q <= 7'h00;
      end else begin
         mask_q <= mask_d;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (reset);

   chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("access not answered after one wait cycle");
   chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_wait_cause: assert property (!waitrequest |-> $past(read || write))
      else $error("waitrequest dropped without a request");
   chk_reserved_zero: assert property (read && !waitrequest && (address == 4'h6 ||
      address >= 4'ha) |-> readdata == 32'h0)
      else $error("reserved location read not zero");
   chk_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
      else $error("read data above register width not zero");
   chk_reset_idle: assert property (@(posedge clock) disable iff (1'b0)
      reset |=> waitrequest && readdata == 32'h0 && txd && !irq)
      else $error("outputs not idle after reset");
   chk_irq_masked: assert property (mask_q == 7'h00 && $past(mask_q) == 7'h00 |-> !irq)
      else $error("interrupt high with all sources masked");
   chk_irq_fall: assert property ($fell(irq) |-> $past(write, 1) || $past(write, 2) ||
      $past(write, 3))
      else $error("interrupt fell without a register write");
endmodule : srn_sva

bind srn_top srn_sva srn_sva_i (
   .clock       (clock),
   .reset       (reset),
   .address     (address),
   .read        (read),
   .write       (write),
   .byteenable  (byteenable),
   .writedata   (writedata),
   .readdata    (readdata),
   .waitrequest (waitrequest),
   .rxd         (rxd),
   .txd         (txd),
   .irq         (irq)
);

/* tb/tb_top.sv */
// Self-checking bench for srn_top: register map, reserved places, noisy
// start and data samples, interrupt raise, mask and clear.
// Assumes srn_sva is bound to srn_top and srn_far_tx drives the rx line.
`timescale 1ns/1ps
module tb_top;
   logic        clock;
   logic        reset;
   logic [3:0]  address;
   logic        read;
   logic        write;
   logic [3:0]  byteenable;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        rxd;
   logic        txd;
   logic        irq;
   logic [31:0] rd;
   int          n_mismatch;
   int          total_checks;
   int          cycles;
   logic [3:0]  bad_idx [3] = '{4'h6, 4'ha, 4'hf};

   srn_top srn_top_i (
      .clock       (clock),
      .reset       (reset),
      .address     (address),
      .read        (read),
      .write       (write),
      .byteenable  (byteenable),
      .writedata   (writedata),
      .readdata    (readdata),
      .waitrequest (waitrequest),
      .rxd         (rxd),
      .txd         (txd),
      .irq         (irq)
   );

   // Reset divisor 4 gives 16 ticks of 4 clocks per bit.
   srn_far_tx #(.BIT_CLKS(64)) srn_far_tx_i (
      .clock (clock),
      .rxd   (rxd)
   );

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // ----------------------------------------------------------------
   // Bus access
   // ----------------------------------------------------------------
   // Holds the request until waitrequest is sampled low, then releases it.
   task automatic bus_xfer(input logic wr, input logic [3:0] idx, input logic [7:0] data);
      address   <= idx;
      writedata <= {24'h000000, data};
      write     <= wr;
      read      <= ~wr;
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read  <= 1'b0;
      @(posedge clock);
   endtask : bus_xfer

   task automatic rchk(input logic [3:0] idx, input logic [7:0] msk, input logic [7:0] exp);
      bus_xfer(1'b0, idx, 8'h00);
      check(rd & {24'hffffff, msk}, {24'h000000, exp});
   endtask : rchk

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset      = 1'b1;
      address    = 4'h0;
      read       = 1'b0;
      write      = 1'b0;
      byteenable = 4'hf;
      writedata  = 32'h0;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rchk(4'h0, 8'hff, 8'h00);
      rchk(4'h1, 8'hff, 8'h04);
      rchk(4'h4, 8'he0, 8'hc0);
      foreach (bad_idx[i]) begin
         bus_xfer(1'b1, bad_idx[i], 8'hff);
         rchk(bad_idx[i], 8'hff, 8'h00);
      end
      // The alternate map shares offsets with the frame control register.
      bus_xfer(1'b1, 4'h2, 8'h0c);
      bus_xfer(1'b1, 4'h5, 8'h80);
      bus_xfer(1'b1, 4'h2, 8'h5a);
      rchk(4'h2, 8'hff, 8'h5a);
      bus_xfer(1'b1, 4'h5, 8'h00);
      rchk(4'h2, 8'hff, 8'h0c);
      bus_xfer(1'b1, 4'h3, 8'h04);
      srn_far_tx_i.send(8'ha5, 0);
      rchk(4'h4, 8'h24, 8'h20);
      rchk(4'h7, 8'hff, 8'ha5);
      // Noise in the start bit while the noise interrupt is still masked.
      srn_far_tx_i.send(8'h3c, 1);
      rchk(4'h4, 8'h24, 8'h24);
      check({31'h0, irq}, 32'h0);
      bus_xfer(1'b1, 4'h9, 8'h04);
      @(posedge clock);
      check({31'h0, irq}, 32'h1);
      rchk(4'h7, 8'hff, 8'h3c);
      rchk(4'h4, 8'h24, 8'h00);
      bus_xfer(1'b1, 4'h8, 8'h04);
      @(posedge clock);
      check({31'h0, irq}, 32'h0);
      srn_far_tx_i.send(8'h01, 2);
      rchk(4'h4, 8'h24, 8'h24);
      rchk(4'h7, 8'hff, 8'h01);
      check({31'h0, irq}, 32'h1);
      // Loopback with even parity: the sent frame comes back to the receiver.
      bus_xfer(1'b1, 4'h2, 8'h82);
      bus_xfer(1'b1, 4'h3, 8'h0c);
      bus_xfer(1'b1, 4'h7, 8'h97);
      repeat (20) @(posedge clock);
      check({31'h0, txd}, 32'h0);
      repeat (780) @(posedge clock);
      check({31'h0, txd}, 32'h1);
      rchk(4'h4, 8'he3, 8'he0);
      rchk(4'h7, 8'hff, 8'h97);
      stop_test();
   end
endmodule : tb_top
